// >>> core/apc_angle_config.sv
// Angle-processing control word with its pre and post linearization stages
//
// Overview of operation
// - Die rotate bit 27 adds half a turn to the angle, wrapping around.
// - Die rotation is the very last step, after the zero shift.
// - Bit 26 picks segment index axis: 0 external encoder, 1 internal reading.
// - Bypass still applies the segment offset; needs segmented enable set too.
// - Bypass bit 25 stops segmented coefficients being applied.
// - Short stroke bit 24 gates limits, clamps and gain; 0 skips them.
// - Invert bit 22 outputs high clamp minus the computed angle.
// - Bit 21 sets post-linearization direction: 0 counterclockwise, 1 clockwise.
// - Segmented linearization runs only while bit 20 is set.
// - Harmonic linearization runs only while bit 19 is set.
// - Bit 18 sets pre-linearization direction: 0 counterclockwise, 1 clockwise.
// - Bit 16 enables input filtering before linearization; off by default.
// - Sixteen-bit zero shift in bits 15:0 is subtracted after linearization.
// - Initialization puts the 12 stored bits into 15:4, zeros in 3:0.
// - After initialization software may write all sixteen zero shift bits.
// - Initialization loads each control bit from its stored field, except spare bit 17, which is not stored and clears.
`timescale 1ns/10ps
`default_nettype none
module apc_angle_config
    import apc_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic INIT_LOAD,
    input wire apc_nvm_t INIT_FIELDS,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [APC_DATA_W-1:0] REG_WDATA,
    output logic [APC_DATA_W-1:0] REG_RDATA,
    output logic REG_RVALID,
    output logic INIT_DONE,
    input wire logic [APC_ANGLE_W-1:0] ANGLE_IN,
    input wire logic ANGLE_IN_VALID,
    output logic [APC_ANGLE_W-1:0] PRE_ANGLE,
    output logic PRE_VALID,
    output apc_chain_t CHAIN_CTRL,
    input wire logic [APC_ANGLE_W-1:0] LIN_ANGLE,
    input wire logic LIN_VALID,
    input wire logic [APC_ANGLE_W-1:0] HIGH_CLAMP,
    output logic [APC_ANGLE_W-1:0] ANGLE_OUT,
    output logic ANGLE_OUT_VALID
);

    if (ADDR_W < 3 || ADDR_W > APC_DATA_W) begin : g_bad_addr
        $error("apc_angle_config: address width cannot reach the control word");
    end

    apc_ctrl_t ctrl_q;
    apc_ctrl_t ctrl_d;
    logic init_done_q;
    logic addr_hit;
    logic sw_write;

    assign addr_hit = (REG_ADDR == ADDR_W'(APC_CTRL_INDEX));
    // Writes before the stored image is loaded would be overwritten anyway
    assign sw_write = REG_WR && addr_hit && init_done_q;

    // Load from storage beats a write in the same cycle
    always_comb begin
        ctrl_d = ctrl_q;
        if (INIT_LOAD) begin
            ctrl_d = apc_from_nvm(INIT_FIELDS);
        end else if (sw_write) begin
            ctrl_d = apc_unpack(REG_WDATA & APC_WRITE_MASK);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ctrl_q <= apc_unpack(APC_CTRL_RESET);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            init_done_q <= 1'b0;
            INIT_DONE <= 1'b0;
        end else begin
            if (INIT_LOAD) begin
                init_done_q <= 1'b1;
            end
            INIT_DONE <= init_done_q;
        end
    end

    // Unmapped word addresses read as zero
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            REG_RDATA <= '0;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= addr_hit ? (apc_pack(ctrl_q) & APC_WRITE_MASK) : '0;
            end
        end
    end

    // Enables for the stages that sit outside this block
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            CHAIN_CTRL <= '0;
        end else begin
            CHAIN_CTRL.filter_enable <= ctrl_q.input_filter_enable;
            CHAIN_CTRL.harmonic_enable <= ctrl_q.harmonic_enable;
            CHAIN_CTRL.seg_enable <= ctrl_q.segmented_enable;
            CHAIN_CTRL.seg_apply_coeff <= ctrl_q.segmented_enable
                && !ctrl_q.segmented_bypass;
            // Offset still goes in under bypass, but only with segmenting on
            CHAIN_CTRL.seg_apply_offset <= ctrl_q.segmented_enable;
            CHAIN_CTRL.seg_ref_internal <= ctrl_q.segment_reference_select;
            CHAIN_CTRL.short_stroke_enable <= ctrl_q.short_stroke;
        end
    end

    // Orientation ahead of filter and linearization
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            PRE_ANGLE <= '0;
            PRE_VALID <= 1'b0;
        end else begin
            PRE_VALID <= ANGLE_IN_VALID;
            if (ANGLE_IN_VALID) begin
                PRE_ANGLE <= ctrl_q.pre_linear_direction ? -ANGLE_IN : ANGLE_IN;
            end
        end
    end

    apc_post_chain #(
        .W(APC_ANGLE_W)
    ) u_post (
        .clk(CLK),
        .reset_n(RESET_N),
        .in_angle(LIN_ANGLE),
        .in_valid(LIN_VALID),
        .cfg(ctrl_q),
        .high_clamp(HIGH_CLAMP),
        .out_angle(ANGLE_OUT),
        .out_valid(ANGLE_OUT_VALID)
    );

    property p_reserved_zero;
        @(posedge CLK) disable iff (!RESET_N)
        REG_RVALID |-> (REG_RDATA & ~APC_WRITE_MASK) == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_init_zero;
        @(posedge CLK) disable iff (!RESET_N)
        INIT_LOAD |=> ctrl_q.output_zero_shift == {$past(INIT_FIELDS.zero_shift), APC_ZERO_PAD};
    endproperty
    a_init_zero: assert property (p_init_zero) else $error("stored zero shift misplaced");

    property p_sw_write;
        @(posedge CLK) disable iff (!RESET_N)
        (sw_write && !INIT_LOAD) ##1 !(REG_WR || INIT_LOAD) ##1 (REG_RD && addr_hit)
            |=> REG_RDATA == ($past(REG_WDATA, 3) & APC_WRITE_MASK);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("written word not read back");

    property p_write_ignored_early;
        @(posedge CLK) disable iff (!RESET_N)
        (!init_done_q && !INIT_LOAD) |=> $stable(ctrl_q);
    endproperty
    a_write_ignored_early: assert property (p_write_ignored_early)
        else $error("word moved early");

    property p_init_short;
        @(posedge CLK) disable iff (!RESET_N)
        INIT_LOAD |-> ##2 CHAIN_CTRL.short_stroke_enable == $past(INIT_FIELDS.short_stroke, 2);
    endproperty
    a_init_short: assert property (p_init_short) else $error("short stroke not loaded");

    property p_bypass;
        @(posedge CLK) disable iff (!RESET_N)
        CHAIN_CTRL.seg_apply_coeff |-> CHAIN_CTRL.seg_apply_offset && CHAIN_CTRL.seg_enable
            && !$past(ctrl_q.segmented_bypass);
    endproperty
    a_bypass: assert property (p_bypass) else $error("coefficients applied under bypass");

    property p_seg_enable;
        @(posedge CLK) disable iff (!RESET_N)
        ##1 CHAIN_CTRL.seg_enable == $past(ctrl_q.segmented_enable)
            && CHAIN_CTRL.seg_ref_internal == $past(ctrl_q.segment_reference_select);
    endproperty
    a_seg_enable: assert property (p_seg_enable) else $error("segment controls wrong");

    property p_harm_filter;
        @(posedge CLK) disable iff (!RESET_N)
        ##1 CHAIN_CTRL.harmonic_enable == $past(ctrl_q.harmonic_enable)
            && CHAIN_CTRL.filter_enable == $past(ctrl_q.input_filter_enable);
    endproperty
    a_harm_filter: assert property (p_harm_filter)
        else $error("harmonic or filter enable wrong");

    property p_pre_dir;
        @(posedge CLK) disable iff (!RESET_N)
        (ANGLE_IN_VALID && ctrl_q.pre_linear_direction) |=>
            PRE_VALID && (PRE_ANGLE + $past(ANGLE_IN)) == '0;
    endproperty
    a_pre_dir: assert property (p_pre_dir) else $error("pre direction wrong");

    property p_pre_pass;
        @(posedge CLK) disable iff (!RESET_N)
        (ANGLE_IN_VALID && !ctrl_q.pre_linear_direction) |=> PRE_ANGLE == $past(ANGLE_IN);
    endproperty
    a_pre_pass: assert property (p_pre_pass) else $error("pre direction altered angle");

    // Watches the reset itself, so it carries no disable
    property p_reset_state;
        @(posedge CLK)
        !RESET_N |=> apc_pack(ctrl_q) == APC_CTRL_RESET && !INIT_DONE && !REG_RVALID
            && !PRE_VALID && !ANGLE_OUT_VALID && CHAIN_CTRL == '0;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset state wrong");

    property p_init_flags_a;
        @(posedge CLK) disable iff (!RESET_N)
        INIT_LOAD |=> ctrl_q.die_rotate == $past(INIT_FIELDS.die_rotate)
            && ctrl_q.segment_reference_select == $past(INIT_FIELDS.segment_reference_select)
            && ctrl_q.segmented_bypass == $past(INIT_FIELDS.segmented_bypass)
            && ctrl_q.short_stroke == $past(INIT_FIELDS.short_stroke)
            && ctrl_q.output_invert == $past(INIT_FIELDS.output_invert);
    endproperty
    a_init_flags_a: assert property (p_init_flags_a)
        else $error("stored flags not loaded");

    property p_init_flags_b;
        @(posedge CLK) disable iff (!RESET_N)
        INIT_LOAD |=> ctrl_q.post_linear_direction == $past(INIT_FIELDS.post_linear_direction)
            && ctrl_q.segmented_enable == $past(INIT_FIELDS.segmented_enable)
            && ctrl_q.harmonic_enable == $past(INIT_FIELDS.harmonic_enable)
            && ctrl_q.pre_linear_direction == $past(INIT_FIELDS.pre_linear_direction)
            && ctrl_q.input_filter_enable == $past(INIT_FIELDS.input_filter_enable)
            && !ctrl_q.spare_rw;
    endproperty
    a_init_flags_b: assert property (p_init_flags_b)
        else $error("stored enables not loaded");

    property p_init_done;
        @(posedge CLK) disable iff (!RESET_N)
        INIT_LOAD |-> ##2 INIT_DONE;
    endproperty
    a_init_done: assert property (p_init_done)
        else $error("init done late");

    property p_rvalid;
        @(posedge CLK) disable iff (!RESET_N)
        ##1 REG_RVALID == $past(REG_RD);
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read valid wrong");

    property p_read_zero;
        @(posedge CLK) disable iff (!RESET_N)
        (REG_RD && addr_hit) |=>
            REG_RDATA[APC_ZERO_MSB:APC_ZERO_LSB] == $past(ctrl_q.output_zero_shift);
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("zero shift read wrong");

    property p_read_miss;
        @(posedge CLK) disable iff (!RESET_N)
        (REG_RD && !addr_hit) |=> REG_RDATA == '0;
    endproperty
    a_read_miss: assert property (p_read_miss)
        else $error("unmapped read not zero");

    property p_write_mask;
        @(posedge CLK) disable iff (!RESET_N)
        (sw_write && !INIT_LOAD) |=>
            apc_pack(ctrl_q) == ($past(REG_WDATA) & APC_WRITE_MASK);
    endproperty
    a_write_mask: assert property (p_write_mask)
        else $error("written word not stored");

    property p_coeff;
        @(posedge CLK) disable iff (!RESET_N)
        ##1 CHAIN_CTRL.seg_apply_coeff
            == ($past(ctrl_q.segmented_enable) && !$past(ctrl_q.segmented_bypass));
    endproperty
    a_coeff: assert property (p_coeff)
        else $error("coefficient enable wrong");

    property p_offset;
        @(posedge CLK) disable iff (!RESET_N)
        ##1 CHAIN_CTRL.seg_apply_offset == $past(ctrl_q.segmented_enable);
    endproperty
    a_offset: assert property (p_offset)
        else $error("segment offset enable wrong");

    property p_short;
        @(posedge CLK) disable iff (!RESET_N)
        ##1 CHAIN_CTRL.short_stroke_enable == $past(ctrl_q.short_stroke);
    endproperty
    a_short: assert property (p_short)
        else $error("short stroke enable wrong");

    property p_pre_hold;
        @(posedge CLK) disable iff (!RESET_N)
        !ANGLE_IN_VALID |=> !PRE_VALID && $stable(PRE_ANGLE);
    endproperty
    a_pre_hold: assert property (p_pre_hold)
        else $error("pre stage moved without input");

endmodule // apc_angle_config
`default_nettype wire

// >>> core/apc_pkg.sv
// Package for the angle-processing control word: layout, types and helpers
package apc_pkg;

    localparam int APC_DATA_W = 32;
    localparam int APC_ANGLE_W = 16;
    localparam int APC_NVM_ZERO_W = 12;
    localparam int APC_CTRL_INDEX = 6;

    localparam int APC_BIT_DIE_ROTATE = 27;
    localparam int APC_BIT_SEG_REF_SEL = 26;
    localparam int APC_BIT_SEG_BYPASS = 25;
    localparam int APC_BIT_SHORT_STROKE = 24;
    localparam int APC_BIT_OUT_INVERT = 22;
    localparam int APC_BIT_POST_DIR = 21;
    localparam int APC_BIT_SEG_ENABLE = 20;
    localparam int APC_BIT_HARM_ENABLE = 19;
    localparam int APC_BIT_PRE_DIR = 18;
    localparam int APC_BIT_SPARE = 17;
    localparam int APC_BIT_FILTER_EN = 16;
    localparam int APC_ZERO_LSB = 0;
    localparam int APC_ZERO_MSB = 15;
    localparam int APC_NVM_ZERO_LSB = 4;

    // Bits 31:28 and 23 carry nothing
    localparam logic [APC_DATA_W-1:0] APC_WRITE_MASK = 32'h0F7F_FFFF;
    localparam logic [APC_DATA_W-1:0] APC_CTRL_RESET = 32'h0000_0000;
    localparam logic [APC_NVM_ZERO_LSB-1:0] APC_ZERO_PAD = 4'h0;

    typedef struct packed {
        logic die_rotate;
        logic segment_reference_select;
        logic segmented_bypass;
        logic short_stroke;
        logic output_invert;
        logic post_linear_direction;
        logic segmented_enable;
        logic harmonic_enable;
        logic pre_linear_direction;
        logic spare_rw;
        logic input_filter_enable;
        logic [APC_ANGLE_W-1:0] output_zero_shift;
    } apc_ctrl_t;

    typedef struct packed {
        logic die_rotate;
        logic segment_reference_select;
        logic segmented_bypass;
        logic short_stroke;
        logic output_invert;
        logic post_linear_direction;
        logic segmented_enable;
        logic harmonic_enable;
        logic pre_linear_direction;
        logic input_filter_enable;
        logic [APC_NVM_ZERO_W-1:0] zero_shift;
    } apc_nvm_t;

    typedef struct packed {
        logic filter_enable;
        logic harmonic_enable;
        logic seg_enable;
        logic seg_apply_coeff;
        logic seg_apply_offset;
        logic seg_ref_internal;
        logic short_stroke_enable;
    } apc_chain_t;

    function automatic logic [APC_DATA_W-1:0] apc_pack(input apc_ctrl_t c);
        logic [APC_DATA_W-1:0] w;
        w = '0;
        w[APC_BIT_DIE_ROTATE] = c.die_rotate;
        w[APC_BIT_SEG_REF_SEL] = c.segment_reference_select;
        w[APC_BIT_SEG_BYPASS] = c.segmented_bypass;
        w[APC_BIT_SHORT_STROKE] = c.short_stroke;
        w[APC_BIT_OUT_INVERT] = c.output_invert;
        w[APC_BIT_POST_DIR] = c.post_linear_direction;
        w[APC_BIT_SEG_ENABLE] = c.segmented_enable;
        w[APC_BIT_HARM_ENABLE] = c.harmonic_enable;
        w[APC_BIT_PRE_DIR] = c.pre_linear_direction;
        w[APC_BIT_SPARE] = c.spare_rw;
        w[APC_BIT_FILTER_EN] = c.input_filter_enable;
        w[APC_ZERO_MSB:APC_ZERO_LSB] = c.output_zero_shift;
        return w;
    endfunction

    function automatic apc_ctrl_t apc_unpack(input logic [APC_DATA_W-1:0] w);
        apc_ctrl_t c;
        c.die_rotate = w[APC_BIT_DIE_ROTATE];
        c.segment_reference_select = w[APC_BIT_SEG_REF_SEL];
        c.segmented_bypass = w[APC_BIT_SEG_BYPASS];
        c.short_stroke = w[APC_BIT_SHORT_STROKE];
        c.output_invert = w[APC_BIT_OUT_INVERT];
        c.post_linear_direction = w[APC_BIT_POST_DIR];
        c.segmented_enable = w[APC_BIT_SEG_ENABLE];
        c.harmonic_enable = w[APC_BIT_HARM_ENABLE];
        c.pre_linear_direction = w[APC_BIT_PRE_DIR];
        c.spare_rw = w[APC_BIT_SPARE];
        c.input_filter_enable = w[APC_BIT_FILTER_EN];
        c.output_zero_shift = w[APC_ZERO_MSB:APC_ZERO_LSB];
        return c;
    endfunction

    function automatic apc_ctrl_t apc_from_nvm(input apc_nvm_t n);
        apc_ctrl_t c;
        c = apc_unpack(APC_CTRL_RESET);
        c.die_rotate = n.die_rotate;
        c.segment_reference_select = n.segment_reference_select;
        c.segmented_bypass = n.segmented_bypass;
        c.short_stroke = n.short_stroke;
        c.output_invert = n.output_invert;
        c.post_linear_direction = n.post_linear_direction;
        c.segmented_enable = n.segmented_enable;
        c.harmonic_enable = n.harmonic_enable;
        c.pre_linear_direction = n.pre_linear_direction;
        c.input_filter_enable = n.input_filter_enable;
        c.output_zero_shift = {n.zero_shift, APC_ZERO_PAD};
        return c;
    endfunction

endpackage

// >>> core/apc_post_chain.sv
// Post-linearization angle pipeline: direction, zero shift, invert, die rotation
`timescale 1ns/10ps
`default_nettype none
module apc_post_chain
    import apc_pkg::*;
#(
    parameter int W = APC_ANGLE_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] in_angle,
    input wire logic in_valid,
    input wire apc_ctrl_t cfg,
    input wire logic [W-1:0] high_clamp,
    output logic [W-1:0] out_angle,
    output logic out_valid
);

    // Full turn maps to 2**W, so wrap-around does the normalizing
    localparam logic [W-1:0] HALF_TURN = {1'b1, {(W-1){1'b0}}};

    if (W < 2 || W > APC_ANGLE_W) begin : g_bad_width
        $error("apc_post_chain: angle width unsupported");
    end

    logic [W-1:0] dir_q;
    logic [W-1:0] zero_q;
    logic [W-1:0] inv_q;
    logic [2:0] vld_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vld_q <= '0;
            out_valid <= 1'b0;
        end else begin
            vld_q <= {vld_q[1:0], in_valid};
            out_valid <= vld_q[2];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dir_q <= '0;
            zero_q <= '0;
            inv_q <= '0;
            out_angle <= '0;
        end else begin
            dir_q <= cfg.post_linear_direction ? -in_angle : in_angle;
            zero_q <= dir_q - cfg.output_zero_shift[W-1:0];
            inv_q <= cfg.output_invert ? (high_clamp - zero_q) : zero_q;
            // Last stage so the offset and inversion see the unrotated angle
            out_angle <= cfg.die_rotate ? (inv_q + HALF_TURN) : inv_q;
        end
    end

    property p_latency;
        @(posedge clk) disable iff (!reset_n)
        in_valid |-> ##4 out_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("post chain latency wrong");

    property p_rotate;
        @(posedge clk) disable iff (!reset_n)
        ##1 (out_angle - $past(inv_q)) == ($past(cfg.die_rotate) ? HALF_TURN : '0);
    endproperty
    a_rotate: assert property (p_rotate) else $error("die rotation wrong");

    property p_invert;
        @(posedge clk) disable iff (!reset_n)
        ##1 $past(cfg.output_invert) |-> (inv_q + $past(zero_q)) == $past(high_clamp);
    endproperty
    a_invert: assert property (p_invert) else $error("inversion wrong");

    property p_zero;
        @(posedge clk) disable iff (!reset_n)
        ##1 (zero_q + $past(cfg.output_zero_shift[W-1:0])) == $past(dir_q);
    endproperty
    a_zero: assert property (p_zero) else $error("zero shift wrong");

    property p_post_dir;
        @(posedge clk) disable iff (!reset_n)
        ##1 $past(cfg.post_linear_direction) |-> (dir_q + $past(in_angle)) == '0;
    endproperty
    a_post_dir: assert property (p_post_dir) else $error("post direction wrong");

endmodule // apc_post_chain
`default_nettype wire

// >>> dv/test_apc_angle_config.sv
// Self-checking bench for the angle-processing control word
`timescale 1ns/10ps
`default_nettype none
module test_apc_angle_config
    import apc_pkg::*;
;
    logic clk, reset_n, init_load, reg_wr, reg_rd, angle_in_valid, lin_valid;
    apc_nvm_t init_fields;
    logic [5:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d, w, r;
    logic reg_rvalid, init_done, pre_valid, angle_out_valid;
    logic [15:0] angle_in, pre_angle, lin_angle, high_clamp, angle_out;
    apc_chain_t chain_ctrl;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    integer seed = 32'h3840C515;

    apc_angle_config #(.ADDR_W(6)) dut (.CLK(clk), .RESET_N(reset_n), .INIT_LOAD(init_load),
        .INIT_FIELDS(init_fields), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
        .INIT_DONE(init_done), .ANGLE_IN(angle_in), .ANGLE_IN_VALID(angle_in_valid),
        .PRE_ANGLE(pre_angle), .PRE_VALID(pre_valid), .CHAIN_CTRL(chain_ctrl),
        .LIN_ANGLE(lin_angle), .LIN_VALID(lin_valid), .HIGH_CLAMP(high_clamp),
        .ANGLE_OUT(angle_out), .ANGLE_OUT_VALID(angle_out_valid));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Stored fields land in their word positions; bit 17 is not stored
    function automatic logic [31:0] nvm_word(input apc_nvm_t f);
        logic [31:0] v;
        v = '0;
        v[APC_BIT_DIE_ROTATE] = f.die_rotate;
        v[APC_BIT_SEG_REF_SEL] = f.segment_reference_select;
        v[APC_BIT_SEG_BYPASS] = f.segmented_bypass;
        v[APC_BIT_SHORT_STROKE] = f.short_stroke;
        v[APC_BIT_OUT_INVERT] = f.output_invert;
        v[APC_BIT_POST_DIR] = f.post_linear_direction;
        v[APC_BIT_SEG_ENABLE] = f.segmented_enable;
        v[APC_BIT_HARM_ENABLE] = f.harmonic_enable;
        v[APC_BIT_PRE_DIR] = f.pre_linear_direction;
        v[APC_BIT_FILTER_EN] = f.input_filter_enable;
        v[15:0] = {f.zero_shift, 4'h0};
        return v;
    endfunction

    function automatic apc_chain_t chain_of(input logic [31:0] v);
        apc_chain_t c;
        c.filter_enable = v[16];
        c.harmonic_enable = v[19];
        c.seg_enable = v[20];
        c.seg_apply_coeff = v[20] & ~v[25];
        c.seg_apply_offset = v[20];
        c.seg_ref_internal = v[26];
        c.short_stroke_enable = v[24];
        return c;
    endfunction

    // Direction, zero shift, invert, then half-turn rotation last
    function automatic logic [15:0] post_of(input logic [15:0] l, input logic [31:0] v,
        input logic [15:0] hc);
        logic [15:0] x;
        x = v[21] ? 16'h0000 - l : l;
        x = x - v[15:0];
        x = v[22] ? hc - x : x;
        x = v[27] ? x + 16'h8000 : x;
        return x;
    endfunction

    function automatic logic [15:0] pre_of(input logic [15:0] a, input logic [31:0] v);
        return v[18] ? 16'h0000 - a : a;
    endfunction

    task automatic rd(input logic [5:0] a, output logic [31:0] q);
        int k;
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        k = 0;
        while (reg_rvalid !== 1'b1 && k < 4) begin
            @(negedge clk);
            k++;
        end
        check(32'(reg_rvalid), 32'h1);
        q = reg_rdata;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // Hang guard, well above the length of the sequence
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        {reset_n, init_load, reg_wr, reg_rd, angle_in_valid, lin_valid} = '0;
        init_fields = '0;
        reg_addr = 6'h00;
        reg_wdata = 32'h0;
        angle_in = 16'h0;
        lin_angle = 16'h0;
        high_clamp = 16'h0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        rd(6'h06, d);
        check(d, APC_CTRL_RESET);
        check(32'(init_done), 32'h0);
        // Writes before initialization are dropped
        wr(6'h06, 32'hFFFFFFFF);
        rd(6'h06, d);
        check(d, APC_CTRL_RESET);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            @(negedge clk);
            init_fields = r[21:0];
            init_load = 1'b1;
            reg_wr = (i == 1);
            reg_addr = 6'h06;
            reg_wdata = 32'h0F7FFFFF;
            @(negedge clk);
            init_load = 1'b0;
            reg_wr = 1'b0;
            repeat (2) @(negedge clk);
            check(32'(init_done), 32'h1);
            rd(6'h06, d);
            check(d, nvm_word(init_fields));
            check(32'(chain_ctrl), 32'(chain_of(nvm_word(init_fields))));
        end
        rd(6'h05, d);
        check(d, 32'h0);
        w = nvm_word(init_fields);
        rd(6'h06, d);
        check(d, w);
        wr(6'h07, $random(seed));
        rd(6'h06, d);
        check(d, w);
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            if (i == 0) r = 32'hFFFFFFFF;
            if (i == 1) r = 32'h0;
            wr(6'h06, r);
            w = r & APC_WRITE_MASK;
            rd(6'h06, d);
            check(d, w);
            check(32'(chain_ctrl), 32'(chain_of(w)));
            r = $random(seed);
            @(negedge clk);
            angle_in = r[15:0];
            angle_in_valid = 1'b1;
            @(negedge clk);
            angle_in_valid = 1'b0;
            check(32'(pre_valid), 32'h1);
            check(32'(pre_angle), 32'(pre_of(r[15:0], w)));
            @(negedge clk);
            lin_angle = r[31:16];
            high_clamp = r[15:0] ^ 16'h5A5A;
            lin_valid = 1'b1;
            @(negedge clk);
            lin_valid = 1'b0;
            n = 1;
            while (angle_out_valid !== 1'b1 && n < 8) begin
                @(negedge clk);
                n++;
            end
            check(32'(n), 32'h4);
            check(32'(angle_out), 32'(post_of(lin_angle, w, high_clamp)));
        end
        // Segmented with the external encoder reference, the usual setup
        wr(6'h06, 32'h0010_0000);
        rd(6'h06, d);
        check(d, 32'h0010_0000);
        check(32'(chain_ctrl), 32'(chain_of(32'h0010_0000)));
        // Reset in mid-run drops the word and the init state
        @(negedge clk);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        check(32'(angle_out), 32'h0);
        check(32'(chain_ctrl), 32'h0);
        reset_n = 1'b1;
        rd(6'h06, d);
        check(d, APC_CTRL_RESET);
        check(32'(init_done), 32'h0);
        end_of_test();
    end
endmodule // test_apc_angle_config
`default_nettype wire
